//--- design/neg_exec.sv
// Purpose: executes no-operation, address register negate and memory negates
// Assumes: memory returns read data one cycle after memRead
// Notes:   memory bus is 32 bits wide so a long needs one read and one write
`timescale 1ns/1ps
`include "neg_params.svh"
module neg_exec
#(
  parameter int PC_W = 21
)
(
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              startValid,
  input  wire logic [1:0]        startOp,
  input  wire logic [2:0]        startMode,
  input  wire logic [2:0]        startRegSel,
  input  wire logic [23:0]       startOperand,
  input  wire logic [23:0]       stackPointer,
  input  wire logic              regLoad,
  input  wire logic [2:0]        regLoadSel,
  input  wire logic [23:0]       regLoadData,
  input  wire logic [2:0]        viewSel,
  input  wire logic [31:0]       memRdata,
  output logic                   ready,
  output logic                   done,
  output logic [PC_W-1:0]        programCounter,
  output logic [5:0]             conditionCodes,
  output logic [23:0]            memAddr,
  output logic                   memRead,
  output logic                   memWrite,
  output logic                   memLong,
  output logic [31:0]            memWdata,
  output logic                   memLock,
  output logic [23:0]            regView
);
  // ****************************************
  // state
  // ****************************************
  neg_pkg::neg_state_e state, next_state;
  neg_pkg::neg_op_e    startOpE;
  logic [1:0]          words, next_words;
  logic [23:0]         agReg [8];
  logic [23:0]         next_agReg [8];
  logic [23:0]         effAddr;
  logic                negaNow;
  logic                next_ready, next_done, next_memRead, next_memWrite;
  logic                next_memLong, next_memLock;
  logic [PC_W-1:0]     next_programCounter;
  logic [5:0]          next_conditionCodes;
  logic [23:0]         next_memAddr, next_regView;
  logic [31:0]         next_memWdata;
  neg_alu_if           alu ();

  neg_negate_alu u_alu
  (
    .bus (alu)
  );

  assign startOpE    = neg_pkg::neg_op_e'(startOp);
  assign negaNow     = ready && startValid && (startOpE == neg_pkg::NEG_OP_NEGATE_ADDRESS_REGISTER);
  assign alu.operand = memRdata;
  assign alu.isLong  = memLong;

  // ****************************************
  // address registers
  // ****************************************
  for (genvar i = 0; i < 8; i++)
  begin : g_agReg
    always_comb
    begin
      if (negaNow && startRegSel == 3'(i))
        next_agReg[i] = 24'h000000 - agReg[i];
      else if (regLoad && regLoadSel == 3'(i))
        next_agReg[i] = regLoadData;
      else
        next_agReg[i] = agReg[i];
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_comb
  begin
    case (neg_pkg::neg_mode_e'(startMode))
      neg_pkg::NEG_AM_IND:   effAddr = agReg[startRegSel];
      neg_pkg::NEG_AM_OFF16: effAddr = agReg[startRegSel] + {{8{startOperand[15]}},
                                                             startOperand[15:0]};
      neg_pkg::NEG_AM_SPOFF: effAddr = stackPointer - {18'h00000, startOperand[5:0]};
      neg_pkg::NEG_AM_ABS16: effAddr = {8'h00, startOperand[15:0]};
      default:               effAddr = startOperand;
    endcase
  end

  always_comb
  begin
    next_state          = state;
    next_words          = words;
    next_done           = 1'b0;
    next_memRead        = 1'b0;
    next_memWrite       = 1'b0;
    next_memLong        = memLong;
    next_memLock        = memLock;
    next_memAddr        = memAddr;
    next_memWdata       = memWdata;
    next_programCounter = programCounter;
    next_conditionCodes = conditionCodes;
    next_regView        = next_agReg[viewSel];
    case (state)
      neg_pkg::NEG_ST_IDLE:
      begin
        if (startValid)
        begin
          case (startOpE)
            neg_pkg::NEG_OP_NOP, neg_pkg::NEG_OP_NEGATE_ADDRESS_REGISTER:
            begin
              // single cycle, flags untouched
              next_done           = 1'b1;
              next_programCounter = programCounter + PC_W'(`NEG_WORDS_ONE);
            end
            default:
            begin
              next_memAddr = effAddr;
              next_memLong = (startOpE == neg_pkg::NEG_OP_LONG);
              next_memLock = 1'b1;
              case (neg_pkg::neg_mode_e'(startMode))
                // undefined mode codes fetch like a 24-bit absolute, so they cost three words
                neg_pkg::NEG_AM_IND, neg_pkg::NEG_AM_SPOFF:   next_words = `NEG_WORDS_ONE;
                neg_pkg::NEG_AM_OFF16, neg_pkg::NEG_AM_ABS16: next_words = `NEG_WORDS_TWO;
                default:                                      next_words = `NEG_WORDS_THREE;
              endcase
              // address arithmetic and long absolutes cost one extra cycle
              case (neg_pkg::neg_mode_e'(startMode))
                neg_pkg::NEG_AM_IND, neg_pkg::NEG_AM_ABS16:
                begin
                  next_state   = neg_pkg::NEG_ST_READ;
                  next_memRead = 1'b1;
                end
                default:
                  next_state = neg_pkg::NEG_ST_ADDR;
              endcase
            end
          endcase
        end
      end
      neg_pkg::NEG_ST_ADDR:
      begin
        next_state   = neg_pkg::NEG_ST_READ;
        next_memRead = 1'b1;
      end
      neg_pkg::NEG_ST_READ:
        next_state = neg_pkg::NEG_ST_WAIT;
      neg_pkg::NEG_ST_WAIT:
      begin
        next_state    = neg_pkg::NEG_ST_WRITE;
        next_memWrite = 1'b1;
        next_memWdata = alu.result;
        next_done     = 1'b1;
        next_conditionCodes[`NEG_CCR_E] = alu.flags.e;
        next_conditionCodes[`NEG_CCR_U] = alu.flags.u;
        next_conditionCodes[`NEG_CCR_N] = alu.flags.n;
        next_conditionCodes[`NEG_CCR_Z] = alu.flags.z;
        next_conditionCodes[`NEG_CCR_V] = alu.flags.v;
        next_conditionCodes[`NEG_CCR_C] = alu.flags.c;
        next_programCounter = programCounter + PC_W'(words);
      end
      neg_pkg::NEG_ST_WRITE:
      begin
        next_state   = neg_pkg::NEG_ST_IDLE;
        next_memLock = 1'b0;
      end
      default:
        next_state = neg_pkg::NEG_ST_IDLE;
    endcase
    next_ready = (next_state == neg_pkg::NEG_ST_IDLE);
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state          <= neg_pkg::NEG_ST_IDLE;
      words          <= `NEG_WORDS_ONE;
      ready          <= 1'b1;
      done           <= 1'b0;
      memRead        <= 1'b0;
      memWrite       <= 1'b0;
      memLong        <= 1'b0;
      memLock        <= 1'b0;
      memAddr        <= 24'h000000;
      memWdata       <= 32'h00000000;
      programCounter <= PC_W'(`NEG_PC_RESET);
      conditionCodes <= `NEG_CCR_RESET;
      regView        <= 24'h000000;
      for (int k = 0; k < 8; k++)
        agReg[k] <= 24'h000000;
    end
    else
    begin
      state          <= next_state;
      words          <= next_words;
      ready          <= next_ready;
      done           <= next_done;
      memRead        <= next_memRead;
      memWrite       <= next_memWrite;
      memLong        <= next_memLong;
      memLock        <= next_memLock;
      memAddr        <= next_memAddr;
      memWdata       <= next_memWdata;
      programCounter <= next_programCounter;
      conditionCodes <= next_conditionCodes;
      regView        <= next_regView;
      agReg          <= next_agReg;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  chk_flags_kept: assert property (@(posedge core_clk) disable iff (reset)
    ready && startValid && startOp inside {2'h0, 2'h1} |=> $stable(conditionCodes))
    else $error("flags changed by nop or register negate");
  chk_single_cycle: assert property (@(posedge core_clk) disable iff (reset)
    ready && startValid && startOp inside {2'h0, 2'h1} |=> done && ready)
    else $error("single cycle op not done in one cycle");
  chk_pc_step: assert property (@(posedge core_clk) disable iff (reset)
    ready && startValid && startOp == 2'h0 |=> programCounter == $past(programCounter) + 1'b1)
    else $error("nop did not advance program counter by one");
  chk_reg_negate: assert property (@(posedge core_clk) disable iff (reset)
    negaNow && viewSel == startRegSel |=> regView == 24'h000000 - $past(agReg[viewSel]))
    else $error("address register negate result wrong");
  chk_word_three: assert property (@(posedge core_clk) disable iff (reset)
    ready && startValid && startOp == 2'h2 && startMode == 3'h0
      |=> memRead ##1 !memWrite ##1 memWrite && done ##1 ready)
    else $error("word negate indirect not three cycles");
  chk_word_four: assert property (@(posedge core_clk) disable iff (reset)
    ready && startValid && startOp == 2'h2 && startMode == 3'h2
      |=> !memRead ##1 memRead ##2 memWrite && done ##1 ready)
    else $error("word negate stack offset not four cycles");
  chk_long_timing: assert property (@(posedge core_clk) disable iff (reset)
    ready && startValid && startOp == 2'h3 && startMode == 3'h4
      |=> !memRead ##1 memRead ##2 memWrite && memLong ##1 ready)
    else $error("long negate 24-bit absolute not four cycles");
  chk_word_store: assert property (@(posedge core_clk) disable iff (reset)
    memWrite && !memLong |-> memWdata == {16'h0000, 16'h0000 - $past(memRdata[15:0])}
      && conditionCodes[`NEG_CCR_Z] == (memWdata[15:0] == 16'h0000))
    else $error("word negate stored value or zero flag wrong");
  chk_long_store: assert property (@(posedge core_clk) disable iff (reset)
    memWrite && memLong |-> memWdata == 32'h00000000 - $past(memRdata)
      && conditionCodes[`NEG_CCR_N] == memWdata[31]
      && conditionCodes[`NEG_CCR_C] == ($past(memRdata) != 32'h00000000))
    else $error("long negate stored value or flags wrong");
  chk_locked_seq: assert property (@(posedge core_clk) disable iff (reset)
    memRead |-> memLock && !ready ##1 memLock && !ready ##1 memLock && memWrite)
    else $error("memory negate sequence not locked");
endmodule

//--- design/neg_params.svh
// Purpose: constants of the negate and no-operation execution block
// Assumes: one core clock at the oscillator rate
// Notes:   types live in neg_pkg
// Operation
// - long negate: negative flag follows bit 31 of the 32-bit result
// - long negate: carry flag set on borrow out of bit 31
// - long negate: store low 32 bits, flags from that 32-bit result (code takes E from bits 35:31 of the 36-bit difference)
// - long negate: 3 cycles/2 words (16-bit abs), 4 cycles/3 words (24-bit)
// - word negate: sign-extend operand to 20 bits, subtract from zero
// - word negate: store only low 16 bits of the 20-bit difference
// - word negate: N Z V C from 16-bit result, E U from 20-bit result
// - word negate: E set when the 20-bit extension bits are in use
// - word negate: U set when the 20-bit result is unnormalized
// - word negate: negative flag from bit 15 of the result
// - word negate: carry set on borrow out of bit 15
// - both memory negates: V on overflow, Z when stored result is zero
// - word negate cycles: 3 for indirect/16-bit abs, 4 otherwise
// - address register negate and no-operation leave all flags alone
// - address register negate and no-operation: one cycle, one word
// - no-operation advances program counter by one and continues
`ifndef NEG_PARAMS_SVH
`define NEG_PARAMS_SVH

`define NEG_OSC_PERIOD_NS 100
`define NEG_PC_RESET      21'h00000
`define NEG_CCR_RESET     6'h00
`define NEG_CCR_C         0
`define NEG_CCR_V         1
`define NEG_CCR_Z         2
`define NEG_CCR_N         3
`define NEG_CCR_U         4
`define NEG_CCR_E         5
`define NEG_WORDS_ONE     2'h1
`define NEG_WORDS_TWO     2'h2
`define NEG_WORDS_THREE   2'h3

`endif

//--- design/neg_pkg.sv
// Purpose: shared types of the negate execution block
// Assumes: nothing
// Notes:   constants live in neg_params.svh
package neg_pkg;
  typedef enum logic [1:0] {NEG_OP_NOP, NEG_OP_NEGATE_ADDRESS_REGISTER, NEG_OP_WORD, NEG_OP_LONG} neg_op_e;
  typedef enum logic [2:0] {NEG_AM_IND, NEG_AM_OFF16, NEG_AM_SPOFF, NEG_AM_ABS16,
                            NEG_AM_ABS24} neg_mode_e;
  typedef enum logic [2:0] {NEG_ST_IDLE, NEG_ST_ADDR, NEG_ST_READ, NEG_ST_WAIT,
                            NEG_ST_WRITE} neg_state_e;
  typedef struct packed
  {
    logic e;
    logic u;
    logic n;
    logic z;
    logic v;
    logic c;
  } neg_flags_s;
endpackage

//--- design/neg_alu_if.sv
// Purpose: carries operand and result between sequencer and negate datapath
// Assumes: purely combinational datapath
// Notes:   none
`timescale 1ns/1ps
interface neg_alu_if;
  logic                   isLong;
  logic [31:0]            operand;
  logic [31:0]            result;
  neg_pkg::neg_flags_s    flags;
  modport alu  (input isLong, input operand, output result, output flags);
  modport user (output isLong, output operand, input result, input flags);
endinterface

//--- design/neg_negate_alu.sv
// Purpose: subtract-from-zero datapath with condition-code generation
// Assumes: word operands sit in the low 16 bits
// Notes:   word path runs 20 bits wide, long path 36 bits wide
`timescale 1ns/1ps
module neg_negate_alu
(
  neg_alu_if.alu bus
);
  logic [19:0] wordDiff;
  logic [35:0] longDiff;

  always_comb
  begin
    wordDiff = 20'h00000 - {{4{bus.operand[15]}}, bus.operand[15:0]};
    longDiff = 36'h000000000 - {{4{bus.operand[31]}}, bus.operand};
    if (bus.isLong)
    begin
      bus.result  = longDiff[31:0];
      bus.flags.n = longDiff[31];
      bus.flags.z = (longDiff[31:0] == 32'h00000000);
      bus.flags.v = (bus.operand == 32'h80000000);
      bus.flags.c = (bus.operand != 32'h00000000);
      bus.flags.e = !((&longDiff[35:31]) || !(|longDiff[35:31]));
      bus.flags.u = !(longDiff[31] ^ longDiff[30]);
    end
    else
    begin
      // only the low half reaches memory; upper bits stay zero
      bus.result  = {16'h0000, wordDiff[15:0]};
      bus.flags.n = wordDiff[15];
      bus.flags.z = (wordDiff[15:0] == 16'h0000);
      bus.flags.v = (bus.operand[15:0] == 16'h8000);
      bus.flags.c = (bus.operand[15:0] != 16'h0000);
      bus.flags.e = !((&wordDiff[19:15]) || !(|wordDiff[19:15]));
      bus.flags.u = !(wordDiff[15] ^ wordDiff[14]);
    end
  end
endmodule

//--- verif/neg_mem_model.sv
// Purpose: data memory partner of the negate block
// Assumes: 32-bit words, read data one cycle after the read strobe
// Notes:   the bench preloads words through mem
`timescale 1ns/1ps
module neg_mem_model
(
  input  wire logic        core_clk,
  input  wire logic [23:0] memAddr,
  input  wire logic        memRead,
  input  wire logic        memWrite,
  input  wire logic        memLong,
  input  wire logic [31:0] memWdata,
  output logic      [31:0] memRdata = 32'h0
);
  logic [31:0] mem [logic [23:0]];
  // outside a read the bus flips every cycle so a late sample cannot pass
  always @(posedge core_clk)
  begin
    memRdata <= (memRead === 1'b1) ? mem[memAddr] : ~memRdata;
    if (memWrite === 1'b1 && memLong === 1'b1)
      mem[memAddr] = memWdata;
    else if (memWrite === 1'b1)
      mem[memAddr] = {mem[memAddr][31:16], memWdata[15:0]};
  end
endmodule

//--- verif/tb.sv
// Purpose: self-checking bench of the negate block
// Assumes: partner memory answers one cycle after each read
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module tb;
  logic        core_clk = 1'b0, reset = 1'b1, startValid = 1'b0, regLoad = 1'b0;
  logic [1:0]  startOp = 2'h0;
  logic [2:0]  startMode = 3'h0, startRegSel = 3'h0, regLoadSel = 3'h0, viewSel = 3'h0;
  logic [23:0] startOperand = 24'h0, regLoadData = 24'h0, stackPointer = 24'h000200;
  logic [31:0] memRdata, memWdata;
  logic        ready, done, memRead, memWrite, memLong, memLock;
  logic [20:0] programCounter;
  logic [5:0]  conditionCodes;
  logic [23:0] memAddr, regView;
  int          fails = 0, totalChecks = 0;
  neg_exec #(.PC_W(21)) u_neg_exec
  (
    .core_clk, .reset, .startValid, .startOp, .startMode, .startRegSel, .startOperand,
    .stackPointer, .regLoad, .regLoadSel, .regLoadData, .viewSel, .memRdata, .ready,
    .done, .programCounter, .conditionCodes, .memAddr, .memRead, .memWrite, .memLong,
    .memWdata, .memLock, .regView
  );
  neg_mem_model u_neg_mem_model
  (
    .core_clk, .memAddr, .memRead, .memWrite, .memLong, .memWdata, .memRdata
  );
  initial forever #50 core_clk = ~core_clk;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expected);
    totalChecks++;
    if (seen !== expected)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, expected, seen);
    end
  endtask

  // {E,U,N,Z,V,C}: E and U from the wide difference, the rest from the stored width
  function automatic logic [5:0] exp_flags(input logic isLong, input logic [31:0] op);
    logic [35:0] r;
    logic [4:0]  ext;
    logic [1:0]  top;
    logic        zero;
    logic        most;
    r = isLong ? 36'h0 - {{4{op[31]}}, op} : {16'h0, 20'h0 - {{4{op[15]}}, op[15:0]}};
    ext = isLong ? r[35:31] : r[19:15];
    top = isLong ? r[31:30] : r[15:14];
    zero = isLong ? r[31:0] == 32'h0 : r[15:0] == 16'h0;
    most = isLong ? op == 32'h8000_0000 : op[15:0] == 16'h8000;
    return {ext != 5'h00 && ext != 5'h1f, top[1] == top[0], top[1], zero, most, !zero};
  endfunction

  // register 3 holds 0x100 and the stack pointer 0x200 throughout
  task automatic run_mem(input logic [1:0] op, input logic [2:0] mode,
                         input logic [23:0] opnd, input logic [31:0] val);
    logic [20:0] pc0 = programCounter;
    logic [5:0]  ccExp = exp_flags(op[0], val);
    logic [31:0] res = op[0] ? 32'h0 - val : {val[31:16], 16'h0 - val[15:0]};
    logic [23:0] addr;
    int          n = 1;
    int          rd = 0;
    case (mode)
      3'h0: addr = 24'h000100;
      3'h1: addr = 24'h000100 + opnd;
      3'h2: addr = stackPointer - {18'h0, opnd[5:0]};
      3'h3: addr = {8'h00, opnd[15:0]};
      default: addr = opnd;
    endcase
    @(posedge core_clk);
    #1;
    u_neg_mem_model.mem[addr] = val;
    startValid = 1'b1;
    startOp = op;
    startMode = mode;
    startRegSel = 3'h3;
    startOperand = opnd;
    @(posedge core_clk);
    #1;
    startValid = 1'b0;
    forever
    begin
      rd += int'(memRead === 1'b1);
      if (memWrite === 1'b1)
        check("lock", 32'(memLock), 32'h1);
      if (done === 1'b1 || n >= 12)
        break;
      @(posedge core_clk);
      #1;
      n++;
    end
    check("cycles", 32'(n), (mode == 3'h0 || mode == 3'h3) ? 32'h3 : 32'h4);
    check("pc", 32'(programCounter - pc0),
          mode == 3'h4 ? 32'h3 : (mode == 3'h0 || mode == 3'h2) ? 32'h1 : 32'h2);
    if (op[0])
      check("flags", 32'(conditionCodes), 32'(ccExp));
    else
      check("flags", 32'(conditionCodes), 32'(ccExp));
    @(posedge core_clk);
    #1;
    check("mem", u_neg_mem_model.mem[addr], res);
    check("reads", 32'(rd), 32'h1);
  endtask

  task automatic t_word();
    @(posedge core_clk);
    #1;
    regLoad = 1'b1;
    regLoadSel = 3'h3;
    regLoadData = 24'h000100;
    @(posedge core_clk);
    #1;
    regLoad = 1'b0;
    run_mem(2'h2, 3'h0, 24'h000000, 32'hdead_ff00);
    run_mem(2'h2, 3'h1, 24'h000010, 32'h1234_4000);
    run_mem(2'h2, 3'h2, 24'h000005, 32'h0000_8000);
    run_mem(2'h2, 3'h3, 24'h002000, 32'h5555_0001);
    run_mem(2'h2, 3'h4, 24'h012345, 32'h0000_0000);
    run_mem(2'h2, 3'h0, 24'h000000, 32'h0000_7fff);
  endtask

  task automatic t_long();
    run_mem(2'h3, 3'h3, 24'h002000, 32'h00aa_ff00);
    run_mem(2'h3, 3'h4, 24'h034560, 32'h8000_0000);
    run_mem(2'h3, 3'h3, 24'h00fffe, 32'h0000_0000);
    run_mem(2'h3, 3'h4, 24'h800000, 32'hffff_ffff);
  endtask

  // register negate then no-operation back to back, flags left nonzero before
  task automatic t_negate_address_register_nop();
    logic [5:0]  cc0 = conditionCodes;
    logic [20:0] pc0 = programCounter;
    @(posedge core_clk);
    #1;
    startValid = 1'b1;
    startOp = 2'h1;
    startRegSel = 3'h3;
    viewSel = 3'h3;
    @(posedge core_clk);
    #1;
    startOp = 2'h0;
    check("done", 32'(done), 32'h1);
    check("pc", 32'(programCounter - pc0), 32'h1);
    @(posedge core_clk);
    #1;
    startValid = 1'b0;
    check("done", 32'(done), 32'h1);
    check("pc", 32'(programCounter - pc0), 32'h2);
    check("flags", 32'(conditionCodes), 32'(cc0));
    check("reg", 32'(regView), 32'h00ff_ff00);
  endtask

  task automatic end_of_test();
    if (fails == 0 && totalChecks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // the scenarios need under 200 cycles; a hang is cut after 3000
  initial
  begin
    #(100 * 3000);
    fails++;
    end_of_test();
  end

  initial
  begin
    repeat (20) @(posedge core_clk);
    #1;
    reset = 1'b0;
    t_word();
    t_long();
    t_negate_address_register_nop();
    end_of_test();
  end
endmodule
